// [rtl/usb_interrupt_status.sv]
// USB device interrupt status register and event logic with AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module usb_interrupt_status #(
    parameter int unsigned SUSPEND_CYCLES = usb_status_pkg::SUSPEND_CYCLES,
    parameter int unsigned FRAME_CYCLES   = usb_status_pkg::FRAME_CYCLES
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire logic [31:0]               hwdata,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire usb_status_pkg::usb_event_s usb_event,
    output logic                           usb_irq,
    output logic                           low_power,
    output logic                           suspend_active,
    output logic [6:0]                     device_address,
    output logic                           module_enable,
    output logic                           ep_regs_reset
);

    // Timer counter width, needed by the limit declarations below
    localparam int CNT_W_L = usb_status_pkg::CNT_W;

    usb_status_pkg::state_s s_q;
    usb_status_pkg::state_s s_d;

    logic [usb_status_pkg::EP_COUNT-1:0] pending;
    logic [usb_status_pkg::EP_COUNT-1:0] pend_hi;
    logic [3:0]                          sel_ep;
    logic                                sel_valid;
    logic [6:0]                          flag_set;
    logic [31:0]                         status_word;
    logic                                addr_ok;
    logic                                wr_now;
    logic [7:0]                          wr_ofs;
    logic [CNT_W_L-1:0]                  suspend_lim;
    logic [CNT_W_L-1:0]                  frame_lim;
    logic                                idle_expired;
    logic                                frame_expired;

    // Lowest set index of a vector; the index fits in four bits
    function automatic logic [3:0] first_set(input logic [usb_status_pkg::EP_COUNT-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = usb_status_pkg::EP_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Long counts are parameters so a simulation can shorten them
    assign suspend_lim = CNT_W_L'(SUSPEND_CYCLES);
    assign frame_lim   = CNT_W_L'(FRAME_CYCLES);

    // Endpoint arbitration: iso and double-buffered bulk first, then lowest number
    assign pending   = s_q.ep_tx | s_q.ep_rx;
    assign pend_hi   = pending & s_q.ep_hi;
    assign sel_valid = |pending;
    assign sel_ep    = (|pend_hi) ? first_set(pend_hi) : first_set(pending);

    // Bus timers; suspend needs strictly more than the idle time
    assign idle_expired  = (s_q.idle_cnt == suspend_lim) && !usb_event.bus_active;
    assign frame_expired = s_q.sof_seen && !s_q.suspended && (s_q.frame_cnt == frame_lim);

    // Hardware set requests for flags 8..14, index 0 is bit 8
    always_comb begin
        flag_set = 7'h00;
        flag_set[usb_status_pkg::OVERRUN_BIT - usb_status_pkg::FLAG_LO] =
            usb_event.buf_overrun && !usb_event.iso_xfer;
        flag_set[usb_status_pkg::ERROR_BIT - usb_status_pkg::FLAG_LO] =
            usb_event.err_timeout | usb_event.err_crc |
            usb_event.err_stuff | usb_event.err_frame;
        flag_set[usb_status_pkg::WAKEUP_BIT - usb_status_pkg::FLAG_LO] =
            usb_event.wake && s_q.suspended;
        flag_set[usb_status_pkg::SUSPEND_BIT - usb_status_pkg::FLAG_LO] =
            !s_q.suspended && !usb_event.bus_reset &&
            (idle_expired || (frame_expired && s_q.miss_cnt == usb_status_pkg::MISSED_LIMIT - 2'h1));
        flag_set[usb_status_pkg::BUS_RESET_BIT - usb_status_pkg::FLAG_LO] = usb_event.bus_reset;
        flag_set[usb_status_pkg::SOF_BIT - usb_status_pkg::FLAG_LO] = usb_event.sof;
        flag_set[usb_status_pkg::MISSED_FRAME_BIT - usb_status_pkg::FLAG_LO] = frame_expired;
    end

    // Status word as software sees it; reserved bits read as zero
    always_comb begin
        status_word = usb_status_pkg::STATUS_RESET;
        status_word[usb_status_pkg::TRANSFER_OK_BIT] = sel_valid;
        status_word[usb_status_pkg::FLAG_HI:usb_status_pkg::FLAG_LO] = s_q.flags;
        status_word[usb_status_pkg::DIR_BIT] = s_q.dir;
        status_word[3:0] = s_q.endpoint_identifier;
    end

    // Address phase accepted when selected, active and the bus is ready
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_now  = s_q.wr_pend;
    assign wr_ofs  = s_q.wr_addr;

    // Next state of the whole block
    always_comb begin
        s_d = s_q;

        // Bus slave: writes land in their data phase, reads take one wait state
        s_d.wr_pend = addr_ok && hwrite;
        s_d.rd_wait = addr_ok && !hwrite;
        if (addr_ok) begin
            s_d.wr_addr = haddr[7:0];
            s_d.rd_addr = haddr[7:0];
        end

        // Software writes to control and configuration fields
        if (wr_now && wr_ofs == usb_status_pkg::CONTROL_OFS) begin
            s_d.enables = hwdata[usb_status_pkg::ENABLE_HI:usb_status_pkg::ENABLE_LO];
            s_d.low_power_bit = hwdata[usb_status_pkg::LOW_POWER_BIT];
        end
        if (wr_now && wr_ofs == usb_status_pkg::ADDRESS_OFS) begin
            s_d.dev_addr  = hwdata[6:0];
            s_d.module_en = hwdata[usb_status_pkg::MODULE_EN_BIT];
        end

        // Endpoint flags: write 0 clears, then completions set on top
        if (wr_now && wr_ofs == usb_status_pkg::EP_STATUS_OFS) begin
            s_d.ep_tx = s_q.ep_tx & hwdata[usb_status_pkg::EP_TX_LO +: usb_status_pkg::EP_COUNT];
            s_d.ep_rx = s_q.ep_rx & hwdata[usb_status_pkg::EP_RX_LO +: usb_status_pkg::EP_COUNT];
            s_d.ep_hi = hwdata[usb_status_pkg::EP_HI_LO +: usb_status_pkg::EP_COUNT];
        end
        if (usb_event.xfer_done && usb_event.xfer_ep < 4'(usb_status_pkg::EP_COUNT)) begin
            if (usb_event.xfer_out) begin
                s_d.ep_rx[usb_event.xfer_ep[2:0]] = 1'b1;
            end else begin
                s_d.ep_tx[usb_event.xfer_ep[2:0]] = 1'b1;
            end
        end

        // Status flags: a write of 0 clears, 1 is ignored, a set wins
        if (wr_now && wr_ofs == usb_status_pkg::STATUS_OFS) begin
            s_d.flags = s_q.flags & hwdata[usb_status_pkg::FLAG_HI:usb_status_pkg::FLAG_LO];
        end
        s_d.flags = s_d.flags | flag_set;

        // Report the winning endpoint and its direction, OUT shown when both wait
        if (sel_valid) begin
            s_d.endpoint_identifier = sel_ep;
            s_d.dir = s_q.ep_rx[sel_ep[2:0]];
        end

        // Idle timer, held off while suspended
        if (usb_event.bus_active || s_q.suspended) begin
            s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt != suspend_lim) begin
            s_d.idle_cnt = s_q.idle_cnt + CNT_W_L'(1);
        end

        // Frame timer runs once frames have started, restarts on each SOF
        if (usb_event.sof) begin
            s_d.sof_seen  = 1'b1;
            s_d.frame_cnt = '0;
            s_d.miss_cnt  = 2'h0;
        end else if (frame_expired) begin
            s_d.frame_cnt = '0;
            s_d.miss_cnt  = (s_q.miss_cnt == usb_status_pkg::MISSED_LIMIT - 2'h1) ? 2'h0 : s_q.miss_cnt + 2'h1;
        end else if (s_q.sof_seen && !s_q.suspended) begin
            s_d.frame_cnt = s_q.frame_cnt + CNT_W_L'(1);
        end

        // Suspend entry disables detection until a wake-up or a bus reset ends it
        if (flag_set[usb_status_pkg::SUSPEND_BIT - usb_status_pkg::FLAG_LO]) begin
            s_d.suspended = 1'b1;
            s_d.sof_seen  = 1'b0;
        end

        // Wake activity ends suspend and drops low-power; hardware clear beats software
        if (usb_event.wake) begin
            s_d.low_power_bit = 1'b0;
            s_d.suspended     = 1'b0;
        end

        // Bus reset: address and endpoint state cleared, configuration kept
        if (usb_event.bus_reset) begin
            s_d.suspended = 1'b0;
            s_d.dev_addr  = usb_status_pkg::ADDR_RESET;
            s_d.ep_tx     = usb_status_pkg::EP_RESET;
            s_d.ep_rx     = usb_status_pkg::EP_RESET;
            s_d.idle_cnt  = '0;
            s_d.frame_cnt = '0;
            s_d.miss_cnt  = 2'h0;
            s_d.sof_seen  = 1'b0;
        end

        // Read data captured in the wait cycle so a preceding write is visible
        if (s_q.rd_wait) begin
            unique case (s_q.rd_addr)
                usb_status_pkg::STATUS_OFS: begin
                    s_d.hrdata = status_word;
                end
                usb_status_pkg::CONTROL_OFS: begin
                    s_d.hrdata = {16'h0000, s_q.enables, 5'h00, s_q.low_power_bit, 2'h0};
                end
                usb_status_pkg::ADDRESS_OFS: begin
                    s_d.hrdata = {24'h000000, s_q.module_en, s_q.dev_addr};
                end
                usb_status_pkg::EP_STATUS_OFS: begin
                    s_d.hrdata = {8'h00, s_q.ep_hi, s_q.ep_rx, s_q.ep_tx};
                end
                default: begin
                    s_d.hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Single state register for the whole block
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus answers: always OKAY, reads stretched by one wait state
    assign hreadyout = !s_q.rd_wait;
    assign hresp     = 1'b0;
    assign hrdata    = s_q.hrdata;

    // One interrupt line, each flag gated by its own enable
    assign usb_irq = |(status_word[usb_status_pkg::ENABLE_HI:usb_status_pkg::ENABLE_LO] & s_q.enables);

    // Outputs to the rest of the controller
    assign low_power      = s_q.low_power_bit;
    assign suspend_active = s_q.suspended;
    assign device_address = s_q.dev_addr;
    assign module_enable  = s_q.module_en;
    assign ep_regs_reset  = usb_event.bus_reset;

endmodule

// [rtl/usb_status_pkg.sv]
// Constants, register map and carrier types for the USB interrupt status block
package usb_status_pkg;

    // Notes on behaviour
    // - Transfer-ok bit 15 set on clean completion, read-only
    // - Bit 14 flags packet buffer overrun/underrun
    // - Never flag overrun during isochronous transfers
    // - Bit 13: timeout, CRC, bit-stuff or frame error
    // - Wake in suspend sets bit 12, clears low-power
    // - Bit 11 set after over 3 ms idle
    // - No suspend detection while suspended until wake or bus reset
    // - Bus reset re-enables suspend detection immediately
    // - Bit 10 set on bus reset signalling
    // - Bus reset clears address and endpoint state
    // - Bit 9 set on every SOF token
    // - Bit 8 set when expected SOF missing
    // - Three missed SOFs in a row raise suspend
    // - Bit 4: 0 for IN, 1 for OUT completion
    // - Endpoint may hold tx and rx flags together
    // - Bits 3:0 carry the requesting endpoint number
    // - Iso/double-buffered first, then lowest endpoint number
    // - Flags clear on write 0, writes of 1 ignored
    // - Flag interrupts only when matching enable set
    // - Low-power bit 2 cleared by bus wake activity

    // Register byte offsets
    localparam logic [7:0] EP_STATUS_OFS = 8'h00;
    localparam logic [7:0] CONTROL_OFS   = 8'h40;
    localparam logic [7:0] STATUS_OFS    = 8'h44;
    localparam logic [7:0] ADDRESS_OFS   = 8'h4C;

    // Status register field positions
    localparam int TRANSFER_OK_BIT  = 15;
    localparam int OVERRUN_BIT      = 14;
    localparam int ERROR_BIT        = 13;
    localparam int WAKEUP_BIT       = 12;
    localparam int SUSPEND_BIT      = 11;
    localparam int BUS_RESET_BIT    = 10;
    localparam int SOF_BIT          = 9;
    localparam int MISSED_FRAME_BIT = 8;
    localparam int DIR_BIT          = 4;
    localparam int FLAG_LO          = 8;
    localparam int FLAG_HI          = 14;

    // Control register field positions
    localparam int LOW_POWER_BIT    = 2;
    localparam int ENABLE_LO        = 8;
    localparam int ENABLE_HI        = 15;

    // Address register field positions
    localparam int MODULE_EN_BIT    = 7;

    // Endpoint status register field positions
    localparam int EP_TX_LO         = 0;
    localparam int EP_RX_LO         = 8;
    localparam int EP_HI_LO         = 16;

    // Reset values
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [6:0]  FLAGS_RESET  = 7'h00;
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [6:0]  ADDR_RESET   = 7'h00;
    localparam logic [7:0]  EP_RESET     = 8'h00;

    // Sizes
    localparam int EP_COUNT   = 8;
    localparam int CNT_W      = 17;
    localparam logic [1:0] MISSED_LIMIT = 2'h3;

    // Timing: clock rate and documented times
    localparam int CLK_KHZ          = 20000;
    localparam int SUSPEND_TIME_US  = 3000;
    localparam int FRAME_TIME_US    = 1000;
    localparam int SUSPEND_CYCLES   = (SUSPEND_TIME_US * CLK_KHZ) / 1000;
    localparam int FRAME_CYCLES     = (FRAME_TIME_US * CLK_KHZ) / 1000;

    // Events from the serial engine, all on hclk
    typedef struct packed {
        logic       xfer_done;
        logic [3:0] xfer_ep;
        logic       xfer_out;
        logic       buf_overrun;
        logic       iso_xfer;
        logic       err_timeout;
        logic       err_crc;
        logic       err_stuff;
        logic       err_frame;
        logic       bus_active;
        logic       wake;
        logic       bus_reset;
        logic       sof;
    } usb_event_s;

    // Whole block state
    typedef struct packed {
        logic [EP_COUNT-1:0] ep_tx;
        logic [EP_COUNT-1:0] ep_rx;
        logic [EP_COUNT-1:0] ep_hi;
        logic [6:0]          flags;
        logic [7:0]          enables;
        logic                low_power_bit;
        logic [6:0]          dev_addr;
        logic                module_en;
        logic                dir;
        logic [3:0]          endpoint_identifier;
        logic [CNT_W-1:0]    idle_cnt;
        logic [CNT_W-1:0]    frame_cnt;
        logic [1:0]          miss_cnt;
        logic                suspended;
        logic                sof_seen;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic                rd_wait;
        logic [7:0]          rd_addr;
        logic [31:0]         hrdata;
    } state_s;

endpackage

// [verif/tb_top.sv]
// Self-checking bench for the USB interrupt status block
`timescale 1ns/1ps
module tb_top;
    localparam int SUSP  = 20;
    localparam int FRAME = 16;
    // Upper half: event vector, lower half: status expected afterwards
    localparam logic [31:0] ROWS [10] = '{32'h0200_4000, 32'h0300_0000, 32'h0080_2000,
        32'h0040_2000, 32'h0020_2000, 32'h0010_2000, 32'h0002_0400, 32'h0004_0000,
        32'h9C00_8013, 32'hA800_8005};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, usb_irq, low_power, suspend_active, module_enable, ep_regs_reset;
    logic [6:0] device_address;
    usb_status_pkg::usb_event_s ev = '0, usb_event;
    int errors = 0, tests_run = 0;

    always #25 hclk = ~hclk;

    usb_host_model u_host (.hclk(hclk), .hresetn(hresetn), .ev_req(ev), .idle_req(idle),
        .usb_event(usb_event));
    usb_interrupt_status #(.SUSPEND_CYCLES(SUSP), .FRAME_CYCLES(FRAME)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .usb_event(usb_event), .usb_irq(usb_irq),
        .low_power(low_power), .suspend_active(suspend_active), .device_address(device_address),
        .module_enable(module_enable), .ep_regs_reset(ep_regs_reset));

    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask
    task automatic pulse(input logic [15:0] e);
        ev <= usb_status_pkg::usb_event_s'(e);
        @(posedge hclk);
        ev <= '0;
        repeat (2) @(posedge hclk);
    endtask

    // Watchdog sized well above the few hundred cycles the run needs
    initial begin
        repeat (6000) @(posedge hclk);
        errors++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("status reset", r, usb_status_pkg::STATUS_RESET);
        for (int i = 0; i < 10; i++) begin
            wr(usb_status_pkg::STATUS_OFS, 32'h0);
            wr(usb_status_pkg::EP_STATUS_OFS, 32'h0);
            pulse(ROWS[i][31:16]);
            rd(usb_status_pkg::STATUS_OFS, r);
            chk("status row", r, {16'h0000, ROWS[i][15:0]});
        end
        // Writing ones must neither set nor clear anything; endpoint flags start clear
        wr(usb_status_pkg::EP_STATUS_OFS, 32'h0);
        pulse(16'h0040);
        wr(usb_status_pkg::STATUS_OFS, 32'h0000_FF1F);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("ones ignored", r & 32'hFFFF_FF00, 32'h0000_2000);
        wr(usb_status_pkg::CONTROL_OFS, 32'h0000_4000);
        @(posedge hclk);
        chk("irq masked", usb_irq, 32'h0);
        wr(usb_status_pkg::CONTROL_OFS, 32'h0000_2000);
        @(posedge hclk);
        chk("irq enabled", usb_irq, 32'h1);
        wr(usb_status_pkg::STATUS_OFS, 32'h0);
        // Endpoint 6 IN, endpoint 2 IN and OUT pending together
        pulse(16'hB000);
        pulse(16'h9000);
        pulse(16'h9400);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("lowest endpoint", r, 32'h0000_8012);
        wr(usb_status_pkg::EP_STATUS_OFS, 32'h0040_FFFF);
        rd(usb_status_pkg::EP_STATUS_OFS, r);
        chk("endpoint flags", r, 32'h0040_0444);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("priority endpoint", r, 32'h0000_8006);
        wr(usb_status_pkg::EP_STATUS_OFS, 32'h0);
        wr(usb_status_pkg::STATUS_OFS, 32'h0);
        // Idle bus leads to suspend; wake leaves it and drops low power
        wr(usb_status_pkg::ADDRESS_OFS, 32'h0000_00A5);
        wr(usb_status_pkg::CONTROL_OFS, 32'h0000_0004);
        idle <= 1'b1;
        repeat (SUSP - 2) @(posedge hclk);
        chk("early suspend", suspend_active, 32'h0);
        repeat (40) @(posedge hclk);
        chk("suspended", suspend_active, 32'h1);
        pulse(16'h0004);
        chk("wake low power", {low_power, suspend_active}, 32'h0);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("wake flags", r & 32'hFFFF_FF00, 32'h0000_1800);
        repeat (SUSP + 4) @(posedge hclk);
        pulse(16'h0002);
        chk("reset address", {module_enable, device_address}, 32'h80);
        chk("reset suspend", suspend_active, 32'h0);
        repeat (SUSP + 4) @(posedge hclk);
        chk("suspend again", suspend_active, 32'h1);
        idle <= 1'b0;
        pulse(16'h0004);
        wr(usb_status_pkg::STATUS_OFS, 32'h0);
        // One frame marker, then no more while the bus stays active: missed frames, then suspend
        pulse(16'h0001);
        repeat (FRAME + 2) @(posedge hclk);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("missed frame", r & 32'hFFFF_FF00, 32'h0000_0300);
        chk("one miss", suspend_active, 32'h0);
        repeat (2 * FRAME + 4) @(posedge hclk);
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("three misses", r & 32'hFFFF_FF00, 32'h0000_0B00);
        // Reset in mid-run while suspended with the module enabled
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("reset outputs", {usb_irq, low_power, suspend_active, module_enable, device_address, hresp,
            hreadyout}, 32'h1);
        chk("reset read data", hrdata, 32'h0);
        hresetn <= 1'b1;
        rd(usb_status_pkg::STATUS_OFS, r);
        chk("status after reset", r, usb_status_pkg::STATUS_RESET);
        finish_test();
    end
endmodule

// [verif/usb_host_model.sv]
// Host-side model that turns bench requests into serial engine events
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire usb_status_pkg::usb_event_s ev_req,
    input  wire logic                       idle_req,
    output usb_status_pkg::usb_event_s      usb_event
);
    // Events leave one edge after the request, so each lasts one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_event <= '0;
        end else begin
            usb_event            <= ev_req;
            usb_event.bus_active <= !idle_req; // Bus silent only for suspend tests
            // Endpoint fields are junk outside a completion, never a stale copy
            if (!ev_req.xfer_done) begin
                usb_event.xfer_ep  <= ~usb_event.xfer_ep;
                usb_event.xfer_out <= ~usb_event.xfer_out;
            end
        end
    end
endmodule

// [verif/usb_status_sva.sv]
// Assertion checker for the USB interrupt status block
`timescale 1ns/1ps
module usb_status_sva (
    input wire logic                       hclk,
    input wire logic                       hresetn,
    input wire logic                       hsel,
    input wire logic [31:0]                haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic                       hready,
    input wire logic [31:0]                hwdata,
    input wire logic                       hreadyout,
    input wire usb_status_pkg::usb_event_s usb_event,
    input wire logic                       low_power,
    input wire logic                       suspend_active,
    input wire logic [6:0]                 device_address,
    input wire logic                       module_enable,
    input wire logic                       ep_regs_reset
);
    logic       wr_q;
    logic [7:0] ofs_q;
    logic       ctl_wr;
    logic       adr_wr;

    // Track the write data phase so register effects can be tied to hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= 1'b0;
            ofs_q <= 8'h00;
        end else if (hready) begin
            wr_q  <= hsel && htrans[1] && hwrite;
            ofs_q <= haddr[7:0];
        end
    end
    assign ctl_wr = wr_q && ofs_q == usb_status_pkg::CONTROL_OFS;
    assign adr_wr = wr_q && ofs_q == usb_status_pkg::ADDRESS_OFS;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_read_wait;
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read data phase length wrong");
    property p_ep_reset;
        ep_regs_reset == usb_event.bus_reset;
    endproperty
    a_ep_reset: assert property (p_ep_reset) else $error("endpoint reset not with bus reset");
    property p_reset_wake;
        usb_event.bus_reset |=> !suspend_active;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("suspend kept after bus reset");
    property p_reset_addr;
        usb_event.bus_reset |=> device_address == 7'h00;
    endproperty
    a_reset_addr: assert property (p_reset_addr) else $error("address kept after bus reset");
    property p_keep_en;
        usb_event.bus_reset && !adr_wr |=> module_enable == $past(module_enable);
    endproperty
    a_keep_en: assert property (p_keep_en) else $error("module enable lost on bus reset");
    property p_wake_lp;
        usb_event.wake |=> !low_power;
    endproperty
    a_wake_lp: assert property (p_wake_lp) else $error("low power kept after wake");
    property p_susp_hold;
        suspend_active && !usb_event.wake && !usb_event.bus_reset |=> suspend_active;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("suspend left without wake");
    property p_ctl_wr;
        ctl_wr && !usb_event.wake |=> low_power == $past(hwdata[2]);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("low power bit not written");
    property p_adr_wr;
        adr_wr && !usb_event.bus_reset |=> {module_enable, device_address} == $past(hwdata[7:0]);
    endproperty
    a_adr_wr: assert property (p_adr_wr) else $error("address register not written");

    c_wake: cover property (suspend_active && usb_event.wake);
    c_reset: cover property (suspend_active && usb_event.bus_reset);
    c_lp: cover property (low_power && usb_event.wake);
endmodule

bind usb_interrupt_status usb_status_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hreadyout, .usb_event, .low_power, .suspend_active, .device_address,
    .module_enable, .ep_regs_reset);
